// >>> hw/tpm_pkg.sv
// package: register map, field layouts and codes of the timer block
package tpm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets on the apb bus
    localparam logic [7:0] TPM_OFS_CTRL   = 8'h00;
    localparam logic [7:0] TPM_OFS_TA_PER = 8'h04;
    localparam logic [7:0] TPM_OFS_TA_HI  = 8'h08;
    localparam logic [7:0] TPM_OFS_TB_CNT = 8'h0c;
    localparam logic [7:0] TPM_OFS_TB_RLD = 8'h10;
    localparam logic [7:0] TPM_OFS_ISTAT  = 8'h14;
    localparam logic [7:0] TPM_OFS_IMASK  = 8'h18;
    localparam logic [7:0] TPM_OFS_STAT   = 8'h1c;

    ////////////////////////////////////////////////////////////////////////
    // timer a operating modes
    typedef enum logic [1:0] {
        TPM_TA_TIMER   = 2'h0,
        TPM_TA_EVENT   = 2'h1,
        TPM_TA_ONESHOT = 2'h2,
        TPM_TA_PWM     = 2'h3
    } tpm_ta_mode_t;

    // timer b operating modes
    typedef enum logic [1:0] {
        TPM_TB_TIMER   = 2'h0,
        TPM_TB_EVENT   = 2'h1,
        TPM_TB_MEASURE = 2'h2,
        TPM_TB_RSVD    = 2'h3
    } tpm_tb_mode_t;

    // control register layout, bit 0 is the timer a start flag
    typedef struct packed {
        logic         tb_meas_sel; // 0 period, 1 width
        tpm_tb_mode_t tb_mode;
        tpm_ta_mode_t ta_mode;
        logic         tb_start;
        logic         ta_start;
    } tpm_ctrl_t;

    // interrupt status and mask layout
    typedef struct packed {
        logic tb;
        logic ta;
    } tpm_irq_t;

    localparam int unsigned TPM_CTRL_W = $bits(tpm_ctrl_t);
    localparam int unsigned TPM_IRQ_W  = $bits(tpm_irq_t);
    localparam int unsigned TPM_CNT_W  = 16;

    localparam tpm_ctrl_t       TPM_CTRL_RST = '0;
    localparam tpm_irq_t        TPM_IRQ_RST  = '0;
    localparam logic [15:0]     TPM_CNT_RST  = 16'h0000;
    localparam logic [15:0]     TPM_CNT_ONE  = 16'h0001;
    localparam logic [15:0]     TPM_CNT_ALL1 = 16'hffff;
    localparam logic [31:0]     TPM_RD_ZERO  = 32'h0000_0000;

endpackage : tpm_pkg

// >>> hw/tpm_sync.sv
// two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none

module tpm_sync (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output var  logic o_sync
);

    logic meta;

    // first stage is seen by the second stage only
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta   <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule : tpm_sync

`default_nettype wire

// >>> hw/tpm_top.sv
// timer a pwm and timer b count / measure channels with apb registers
//
// Functional notes
// R1 - selecting pwm mode for timer a from timer or event mode, including the first selection after reset, sets the timer a request bit.
// R2 - software that uses the timer a interrupt clears its request bit after such a mode change.
// R3 - clearing the timer a start flag while pwm pulses run stops the counter.
// R4 - if the pulse output is high when pwm counting stops, it goes low and the timer a request bit is set.
// R5 - if the pulse output is already low when pwm counting stops, it stays low and no request is raised.
// R6 - in timer b timer or event mode a counter read returns the live count.
// R7 - a timer b counter read that meets the reload moment returns all ones.
// R8 - a timer b value written while halted in timer or event mode reads back unchanged until counting starts.
// R9 - changing the measurement select bit after measuring has started sets the timer b request bit.
// R10 - the first effective edge after a measurement start loads an undefined value into the reload register and raises no request.
// R11 - a request bit stays set until software clears it or the interrupt is accepted.
`timescale 1ns/1ps
`default_nettype none

module tpm_top
    import tpm_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output var  logic [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // interrupt acceptance strobes from the interrupt controller
    input  wire logic        i_ta_int_ack,
    input  wire logic        i_tb_int_ack,
    // timer b input pin (events or measured signal)
    input  wire logic        i_tb_in_pin,
    // timer a pulse pin and interrupt line
    output var  logic        o_timer_a_pulse_output,
    output logic             o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    typedef enum logic [2:0] {
        TPM_MS_IDLE  = 3'b001,
        TPM_MS_FIRST = 3'b010,
        TPM_MS_RUN   = 3'b100
    } tpm_ms_state_t;

    tpm_ctrl_t     ctrl;
    tpm_irq_t      istat;
    tpm_irq_t      imask;
    tpm_ms_state_t ms_state;
    tpm_ms_state_t next_ms_state;
    logic [15:0]   ta_per;
    logic [15:0]   ta_hi;
    logic [15:0]   ta_cnt;
    logic          ta_start_q;
    logic [15:0]   tb_cnt;
    logic [15:0]   tb_rld;
    logic          tb_start_q;
    logic          tb_pin;
    logic          tb_pin_q;
    logic          tb_rise;
    logic          tb_edge;
    logic          tb_tick;
    logic          tb_reload;
    logic          ta_pwm;
    logic          ta_stop;
    logic          ta_pwm_fall;
    logic          ta_uflow;
    logic          tb_meas;
    logic          setup;
    logic          wr_en;
    logic          rd_en;
    logic          addr_ok;
    tpm_ctrl_t     wr_ctrl;
    tpm_irq_t      set_irq;
    tpm_irq_t      clr_irq;
    tpm_irq_t      ack_irq;
    logic [31:0]   next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // sticky bit: a hardware set wins over any clear in the same cycle
    function automatic logic sticky(input logic cur, input logic set,
                                    input logic clr);
        sticky = set | (cur & ~clr);
    endfunction : sticky

    // zero-extends a 16-bit value onto the 32-bit read bus
    function automatic logic [31:0] rd16(input logic [15:0] v);
        rd16 = {16'h0000, v};
    endfunction : rd16

    ////////////////////////////////////////////////////////////////////////
    // apb decode: writes land at the access edge, reads are fetched in
    // the setup cycle so that data is stable from a flop when pready rises
    assign setup    = i_psel & ~i_penable;
    assign wr_en    = i_psel & i_penable & i_pwrite;
    assign rd_en    = setup & ~i_pwrite;
    assign wr_ctrl  = tpm_ctrl_t'(i_pwdata[TPM_CTRL_W-1:0]);
    assign o_pready = i_psel & i_penable; // zero wait states

    always_comb begin
        case (i_paddr)
            TPM_OFS_CTRL, TPM_OFS_TA_PER, TPM_OFS_TA_HI,
            TPM_OFS_TB_CNT, TPM_OFS_TB_RLD, TPM_OFS_ISTAT,
            TPM_OFS_IMASK, TPM_OFS_STAT: addr_ok = 1'b1;
            default:                     addr_ok = 1'b0;
        endcase
    end

    assign o_pslverr = o_pready & ~addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        next_rdata = TPM_RD_ZERO;
        case (i_paddr)
            TPM_OFS_CTRL:   next_rdata = 32'(ctrl);
            TPM_OFS_TA_PER: next_rdata = rd16(ta_per);
            TPM_OFS_TA_HI:  next_rdata = rd16(ta_hi);
            TPM_OFS_TB_CNT: begin
                // a read on the reload cycle sees all ones
                if (tb_reload) begin
                    next_rdata = rd16(TPM_CNT_ALL1); // R7
                end else begin
                    next_rdata = rd16(tb_cnt); // R6 R8
                end
            end
            TPM_OFS_TB_RLD: next_rdata = rd16(tb_rld);
            TPM_OFS_ISTAT:  next_rdata = 32'(istat);
            TPM_OFS_IMASK:  next_rdata = 32'(imask);
            TPM_OFS_STAT:   next_rdata = {29'h0000_0000, tb_start_q,
                                          ta_start_q,
                                          o_timer_a_pulse_output};
            default:        next_rdata = TPM_RD_ZERO;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_prdata <= TPM_RD_ZERO;
        end else if (rd_en) begin
            o_prdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and timer a setting registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl   <= TPM_CTRL_RST;
            ta_per <= TPM_CNT_RST;
            ta_hi  <= TPM_CNT_RST;
            imask  <= TPM_IRQ_RST;
        end else if (wr_en) begin
            case (i_paddr)
                TPM_OFS_CTRL:   ctrl   <= wr_ctrl;
                TPM_OFS_TA_PER: ta_per <= i_pwdata[15:0];
                TPM_OFS_TA_HI:  ta_hi  <= i_pwdata[15:0];
                TPM_OFS_IMASK:  imask  <= tpm_irq_t'(i_pwdata[1:0]);
                default:        ;
            endcase
        end
    end

    // start flags delayed one cycle to see the flag being cleared
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ta_start_q <= 1'b0;
            tb_start_q <= 1'b0;
        end else begin
            ta_start_q <= ctrl.ta_start;
            tb_start_q <= ctrl.tb_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer a: pwm counts up to the period, output high below the high
    // count; other modes count down and flag an underflow
    assign ta_pwm  = (ctrl.ta_mode == TPM_TA_PWM);
    assign ta_stop = ta_pwm & ta_start_q & ~ctrl.ta_start;
    assign ta_uflow = ~ta_pwm & ctrl.ta_start & (ta_cnt == TPM_CNT_RST);
    assign ta_pwm_fall = ta_pwm & ctrl.ta_start & o_timer_a_pulse_output
                       & (ta_cnt >= ta_hi);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ta_cnt <= TPM_CNT_RST;
        end else if (!ctrl.ta_start) begin
            // counter holds while stopped
            ta_cnt <= ta_cnt; // R3
        end else if (ta_pwm) begin
            ta_cnt <= (ta_cnt >= ta_per) ? TPM_CNT_RST : ta_cnt + TPM_CNT_ONE;
        end else begin
            ta_cnt <= ta_uflow ? ta_per : ta_cnt - TPM_CNT_ONE;
        end
    end

    // pulse pin: a stop with the pin high forces it low, a stop with it
    // low leaves it alone since the stopped counter no longer moves it
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_timer_a_pulse_output <= 1'b0;
        end else if (!ta_pwm) begin
            o_timer_a_pulse_output <= 1'b0;
        end else if (!ctrl.ta_start) begin
            o_timer_a_pulse_output <= 1'b0; // R4 R5
        end else begin
            o_timer_a_pulse_output <= (ta_cnt < ta_hi);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer b input pin: synchronise, then find edges
    tpm_sync u_tb_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   (i_tb_in_pin),
        .o_sync    (tb_pin)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tb_pin_q <= 1'b0;
        end else begin
            tb_pin_q <= tb_pin;
        end
    end

    assign tb_rise = tb_pin & ~tb_pin_q;
    // width measurement uses both edges, period measurement rising only
    assign tb_edge = ctrl.tb_meas_sel ? (tb_pin ^ tb_pin_q) : tb_rise;
    assign tb_meas = (ctrl.tb_mode == TPM_TB_MEASURE);

    always_comb begin
        case (ctrl.tb_mode)
            TPM_TB_TIMER: tb_tick = 1'b1;
            TPM_TB_EVENT: tb_tick = tb_rise;
            default:      tb_tick = 1'b0;
        endcase
    end

    assign tb_reload = ctrl.tb_start & tb_tick & (tb_cnt == TPM_CNT_RST);

    ////////////////////////////////////////////////////////////////////////
    // timer b measurement sequencer
    always_comb begin
        next_ms_state = ms_state;
        case (ms_state)
            TPM_MS_IDLE:
                if (tb_meas && ctrl.tb_start) next_ms_state = TPM_MS_FIRST;
            TPM_MS_FIRST:
                if (!(tb_meas && ctrl.tb_start)) next_ms_state = TPM_MS_IDLE;
                else if (tb_edge) next_ms_state = TPM_MS_RUN;
            TPM_MS_RUN:
                if (!(tb_meas && ctrl.tb_start)) next_ms_state = TPM_MS_IDLE;
            default: next_ms_state = TPM_MS_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ms_state <= TPM_MS_IDLE;
        end else begin
            ms_state <= next_ms_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer b counter and reload register; outside measure mode a write while halted loads
    // both, a write while counting only the reload for the next cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tb_cnt <= TPM_CNT_RST;
            tb_rld <= TPM_CNT_RST;
        end else if (wr_en && i_paddr == TPM_OFS_TB_CNT && !tb_meas) begin
            tb_rld <= i_pwdata[15:0];
            if (!ctrl.tb_start) begin
                tb_cnt <= i_pwdata[15:0]; // R8
            end
        end else if (tb_meas) begin
            if (ms_state == TPM_MS_IDLE) begin
                tb_cnt <= TPM_CNT_RST;
            end else if (tb_edge) begin
                // the first capture holds whatever was counted before
                // the signal was seen, so its value means nothing
                tb_rld <= tb_cnt; // R10
                tb_cnt <= TPM_CNT_RST;
            end else begin
                tb_cnt <= tb_cnt + TPM_CNT_ONE;
            end
        end else if (tb_reload) begin
            tb_cnt <= tb_rld;
        end else if (ctrl.tb_start && tb_tick) begin
            tb_cnt <= tb_cnt - TPM_CNT_ONE; // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt event sources
    always_comb begin
        set_irq = TPM_IRQ_RST;
        // entering pwm from timer or event mode, reset mode is timer
        if (wr_en && i_paddr == TPM_OFS_CTRL && wr_ctrl.ta_mode == TPM_TA_PWM
            && (ctrl.ta_mode == TPM_TA_TIMER
                || ctrl.ta_mode == TPM_TA_EVENT)) begin
            set_irq.ta = 1'b1; // R1
        end
        if (ta_stop && o_timer_a_pulse_output) begin
            set_irq.ta = 1'b1; // R4
        end
        if (ta_pwm_fall || ta_uflow) begin
            set_irq.ta = 1'b1;
        end
        // select bit flipped while a measurement is under way
        if (wr_en && i_paddr == TPM_OFS_CTRL && ms_state != TPM_MS_IDLE
            && wr_ctrl.tb_meas_sel != ctrl.tb_meas_sel) begin
            set_irq.tb = 1'b1; // R9
        end
        if (ms_state == TPM_MS_RUN && tb_edge) begin
            set_irq.tb = 1'b1; // R10
        end
        if (!tb_meas && tb_reload) begin
            set_irq.tb = 1'b1;
        end
    end

    assign clr_irq = (wr_en && i_paddr == TPM_OFS_ISTAT)
                   ? tpm_irq_t'(i_pwdata[1:0]) : TPM_IRQ_RST;
    assign ack_irq = '{tb: i_tb_int_ack, ta: i_ta_int_ack};

    // request bits clear by write-one or acceptance, never by themselves
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            istat <= TPM_IRQ_RST;
        end else begin
            istat.ta <= sticky(istat.ta, set_irq.ta,
                               clr_irq.ta | ack_irq.ta); // R11
            istat.tb <= sticky(istat.tb, set_irq.tb,
                               clr_irq.tb | ack_irq.tb); // R11
        end
    end

    assign o_irq = |(istat & imask);

endmodule : tpm_top

`default_nettype wire

// >>> tb/tpm_top_properties.sv
// checker: apb timing and interrupt properties seen at the timer ports
`timescale 1ns/1ps
`default_nettype none

module tpm_top_properties
    import tpm_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_ta_int_ack,
    input wire logic        i_tb_int_ack,
    input wire logic        i_tb_in_pin,
    input wire logic        o_timer_a_pulse_output,
    input wire logic        o_irq
);
    ////////////////////////////////////////////////////////////////////////
    // shadow of control and mask, since modes are invisible at the ports
    logic      wr_en, unmapped, wr_ctrl, sel_pwm, stop_hi, meas_chg, clr_any;
    tpm_ctrl_t ctrl_q;
    tpm_irq_t  mask_q;
    assign wr_en    = i_psel & i_penable & i_pwrite;
    assign unmapped = i_paddr > TPM_OFS_STAT || |i_paddr[1:0];
    assign wr_ctrl  = wr_en && i_paddr == TPM_OFS_CTRL;
    assign sel_pwm  = wr_ctrl && i_pwdata[3:2] == 2'h3 && mask_q.ta
                      && ctrl_q.ta_mode inside {TPM_TA_TIMER, TPM_TA_EVENT};
    assign stop_hi  = wr_ctrl && ctrl_q.ta_mode == TPM_TA_PWM && mask_q.ta
                      && ctrl_q.ta_start && !i_pwdata[0]
                      && o_timer_a_pulse_output;
    assign meas_chg = wr_ctrl && ctrl_q.tb_mode == TPM_TB_MEASURE
                      && ctrl_q.tb_start && i_pwdata[5:4] == 2'h2
                      && i_pwdata[1] && mask_q.tb
                      && i_pwdata[6] != ctrl_q.tb_meas_sel;
    // ack or status / mask write are the only ways a request may drop
    assign clr_any  = i_ta_int_ack || i_tb_int_ack || (wr_en
                      && (i_paddr == TPM_OFS_ISTAT || i_paddr == TPM_OFS_IMASK));

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl_q <= TPM_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= tpm_ctrl_t'(i_pwdata[TPM_CTRL_W-1:0]);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mask_q <= TPM_IRQ_RST;
        end else if (wr_en && i_paddr == TPM_OFS_IMASK) begin
            mask_q <= tpm_irq_t'(i_pwdata[TPM_IRQ_W-1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    chk_ready_zero_wait: assert property (i_psel && i_penable |-> o_pready)
        else $error("pready low in access phase");
    chk_slverr_unmapped: assert property
        (i_psel && i_penable |-> o_pslverr == unmapped)
        else $error("pslverr does not match address decode");
    chk_unmapped_read: assert property (i_psel && i_penable && !i_pwrite
        && unmapped |-> o_prdata == TPM_RD_ZERO)
        else $error("unmapped read not zero");
    chk_cnt_upper_zero: assert property (i_psel && i_penable && !i_pwrite
        && i_paddr == TPM_OFS_TB_CNT |-> o_prdata[31:16] == 16'h0000)
        else $error("counter read upper half not zero");
    chk_irq_after_reset: assert property
        (@(posedge i_ref_clk) disable iff (1'b0) i_rst |=> !o_irq)
        else $error("irq high after reset");
    chk_irq_masked: assert property (mask_q == TPM_IRQ_RST |-> !o_irq)
        else $error("irq high with all masked");
    chk_irq_sticky: assert property (o_irq && !clr_any |=> o_irq)
        else $error("request dropped without clear");
    chk_pwm_select_irq: assert property (sel_pwm |=> o_irq)
        else $error("no request on pwm selection");
    chk_pwm_stop_low: assert property (stop_hi
        |-> ##[1:4] (!o_timer_a_pulse_output && o_irq))
        else $error("pulse not low with request after stop");
    chk_meas_sel_irq: assert property (meas_chg |-> ##[1:2] o_irq)
        else $error("no request on measure select change");

    cov_pwm_select: cover property (sel_pwm);
    cov_pwm_stop: cover property (stop_hi);
    cov_meas_change: cover property (meas_chg);

endmodule : tpm_top_properties

bind tpm_top tpm_top_properties i_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_ta_int_ack(i_ta_int_ack),
    .i_tb_int_ack(i_tb_int_ack), .i_tb_in_pin(i_tb_in_pin),
    .o_timer_a_pulse_output(o_timer_a_pulse_output), .o_irq(o_irq)
);

`default_nettype wire

// >>> tb/tpm_ext_loop.sv
// partner: board buffer looping the pulse pin back to the timer b pin
`timescale 1ns/1ps
`default_nettype none

module tpm_ext_loop (
    input  wire logic i_ref_clk,
    input  wire logic i_pulse,
    input  wire logic i_loop_en,
    output wire logic o_pin
);
    logic dly = 1'b0;

    // one clock of board delay; pull-down holds the pin low when unlooped
    always_ff @(posedge i_ref_clk) begin
        dly <= i_loop_en & i_pulse;
    end
    assign o_pin = dly;
endmodule : tpm_ext_loop

`default_nettype wire

// >>> tb/tpm_top_tb.sv
// testbench: register rows, pwm stop cases, timer b reads and measuring
`timescale 1ns/1ps
`default_nettype none

module tpm_top_tb
    import tpm_pkg::*;
;
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic        err;
    } tpm_row_t;

    localparam tpm_row_t ROWS [0:13] = '{
        '{TPM_OFS_CTRL,   1'b0, 32'h0, 32'h0, 1'b0},
        '{TPM_OFS_TA_PER, 1'b0, 32'h0, 32'h0, 1'b0},
        '{TPM_OFS_TB_RLD, 1'b0, 32'h0, 32'h0, 1'b0},
        '{TPM_OFS_ISTAT,  1'b0, 32'h0, 32'h0, 1'b0},
        '{TPM_OFS_IMASK,  1'b0, 32'h0, 32'h0, 1'b0},
        '{TPM_OFS_STAT,   1'b0, 32'h0, 32'h0, 1'b0},
        '{TPM_OFS_TA_HI,  1'b1, 32'hffff_0056, 32'h0, 1'b0},
        '{TPM_OFS_TA_HI,  1'b0, 32'h0, 32'h0000_0056, 1'b0},
        '{TPM_OFS_IMASK,  1'b1, 32'h3, 32'h0, 1'b0},
        '{TPM_OFS_IMASK,  1'b0, 32'h0, 32'h3, 1'b0},
        '{TPM_OFS_TB_CNT, 1'b1, 32'h00ab, 32'h0, 1'b0},
        '{TPM_OFS_TB_CNT, 1'b0, 32'h0, 32'h00ab, 1'b0},
        '{8'h20,          1'b1, 32'h5, 32'h0, 1'b1},
        '{8'h20,          1'b0, 32'h0, 32'h0, 1'b1}
    };

    logic        i_ref_clk, i_rst, i_psel, i_penable, i_pwrite, loop_en;
    logic        i_ta_int_ack, i_tb_int_ack, er;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, rd;
    wire  [31:0] o_prdata;
    wire         o_pready, o_pslverr, tb_pin, o_timer_a_pulse_output, o_irq;
    int          mismatches = 0, comparisons = 0, cycles = 0, bad, saw;

    tpm_top i_tpm_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_ta_int_ack(i_ta_int_ack), .i_tb_int_ack(i_tb_int_ack),
        .i_tb_in_pin(tb_pin), .o_irq(o_irq),
        .o_timer_a_pulse_output(o_timer_a_pulse_output));
    tpm_ext_loop i_tpm_ext_loop (.i_ref_clk(i_ref_clk),
        .i_pulse(o_timer_a_pulse_output), .i_loop_en(loop_en), .o_pin(tb_pin));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        @(posedge i_ref_clk);
        while (o_pready !== 1'b1) @(posedge i_ref_clk);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, x);
        apb(a, 1'b0, 32'h0);
        check(rd & m, x);
    endtask : rchk

    task automatic ack(input logic [1:0] m);
        i_ta_int_ack <= m[0];
        i_tb_int_ack <= m[1];
        @(posedge i_ref_clk);
        i_ta_int_ack <= 1'b0;
        i_tb_int_ack <= 1'b0;
    endtask : ack

    // run pwm with a given high count, then clear the start flag
    task automatic pwm_stop(input logic [31:0] hi, px, ix);
        wr(TPM_OFS_TA_HI, hi);
        wr(TPM_OFS_CTRL, 32'h0000_000d);
        repeat (12) @(posedge i_ref_clk);
        wr(TPM_OFS_ISTAT, 32'h3);
        @(negedge i_ref_clk);
        check({31'h0, o_timer_a_pulse_output}, px);
        wr(TPM_OFS_CTRL, 32'h0000_000c);
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        check({31'h0, o_timer_a_pulse_output}, 32'h0);
        rchk(TPM_OFS_ISTAT, 32'h1, ix);
    endtask : pwm_stop

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // a hang counts as a mismatch and ends the run
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        {i_rst, i_psel, i_penable, i_pwrite, loop_en} = 5'b10000;
        {i_ta_int_ack, i_tb_int_ack, i_paddr, i_pwdata} = '0;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 14; k++) begin
            apb(ROWS[k].addr, ROWS[k].wr, ROWS[k].wdata);
            if (!ROWS[k].wr) check(rd, ROWS[k].exp);
            check({31'h0, er}, {31'h0, ROWS[k].err});
        end
        // oneshot, timer, event into pwm: only the last two raise a request
        for (int k = 0; k < 3; k++) begin
            wr(TPM_OFS_CTRL, {28'h0, 2'((k + 2) % 3), 2'b00});
            wr(TPM_OFS_ISTAT, 32'h3);
            wr(TPM_OFS_CTRL, 32'h0000_000c);
            rchk(TPM_OFS_ISTAT, 32'h1, {31'h0, k != 0});
        end
        check({31'h0, o_irq}, 32'h1);
        ack(2'b01);
        rchk(TPM_OFS_ISTAT, 32'h1, 32'h0);
        wr(TPM_OFS_TA_PER, 32'h9);
        pwm_stop(32'h000a, 32'h1, 32'h1);
        pwm_stop(32'h0000, 32'h0, 32'h0);
        // timer b free counting from 5; uneven read spacing meets the reload
        wr(TPM_OFS_TB_CNT, 32'h5);
        wr(TPM_OFS_CTRL, 32'h0000_0002);
        bad = 0;
        saw = 0;
        for (int k = 0; k < 20; k++) begin
            apb(TPM_OFS_TB_CNT, 1'b0, 32'h0);
            if (rd === 32'h0000_ffff) saw++;
            else if ((rd <= 32'h5) !== 1'b1) bad++;
            if (k % 2 == 1) @(posedge i_ref_clk);
        end
        check(32'(bad), 32'h0);
        check({31'h0, saw != 0}, 32'h1);
        // measuring the looped pulse: first edge gives no request
        wr(TPM_OFS_CTRL, 32'h0);
        wr(TPM_OFS_ISTAT, 32'h3);
        wr(TPM_OFS_TA_HI, 32'h5);
        loop_en <= 1'b1;
        wr(TPM_OFS_CTRL, 32'h0000_002f);
        repeat (6) @(posedge i_ref_clk);
        rchk(TPM_OFS_ISTAT, 32'h2, 32'h0);
        repeat (12) @(posedge i_ref_clk);
        rchk(TPM_OFS_ISTAT, 32'h2, 32'h2);
        wr(TPM_OFS_CTRL, 32'h0000_002e);
        repeat (8) @(posedge i_ref_clk);
        wr(TPM_OFS_ISTAT, 32'h3);
        rchk(TPM_OFS_ISTAT, 32'h2, 32'h0);
        wr(TPM_OFS_CTRL, 32'h0000_006e);
        rchk(TPM_OFS_ISTAT, 32'h2, 32'h2);
        ack(2'b10);
        rchk(TPM_OFS_ISTAT, 32'h2, 32'h0);
        // event count, then reset mid-run
        wr(TPM_OFS_CTRL, 32'h5c);
        wr(TPM_OFS_TB_CNT, 32'h2);
        wr(TPM_OFS_CTRL, 32'h5f);
        rchk(TPM_OFS_TB_CNT, 32'hffff, 32'h2);
        repeat (30) @(posedge i_ref_clk);
        rchk(TPM_OFS_ISTAT, 32'h2, 32'h2);
        i_rst <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        check({30'h0, o_irq, o_timer_a_pulse_output}, 32'h0);
        rchk(TPM_OFS_CTRL, 32'hffff_ffff, 32'h0);
        give_verdict();
    end
endmodule : tpm_top_tb

`default_nettype wire
